/* logic/bfw_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants for the bus fault and wake status register group.
// ----------------------------------------------------------------------------
package bfw_pkg;

  // ----------------------------------------------------------------------------
  // Register addresses on the serial register interface (7-bit).
  // ----------------------------------------------------------------------------
  localparam logic [6:0] ADDR_LIN_FAULT_STATUS_B   = 7'h45;
  localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS_A = 7'h46;
  localparam logic [6:0] ADDR_WAKE_SOURCE_STATUS_B = 7'h47;
  localparam logic [6:0] ADDR_PIN_LEVEL_STATUS     = 7'h48;

  // ----------------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------------
  localparam int THIRD_LIN_FAULT_LSB  = 3;
  localparam int SECOND_LIN_FAULT_LSB = 1;
  localparam int REG_MODE_SWITCH_BIT  = 7;
  localparam int CAN_WAKE_BIT         = 5;
  localparam int TIMER_WAKE_BIT       = 4;
  localparam int PIN_WAKE_BIT         = 0;
  localparam int THIRD_LIN_WAKE_BIT   = 2;
  localparam int SECOND_LIN_WAKE_BIT  = 1;
  localparam int FIRST_LIN_WAKE_BIT   = 0;
  localparam int TEST_LEVEL_BIT       = 7;
  localparam int LEVEL_RSVD_ONE_BIT   = 6;
  localparam int FAIL_CFG_MIRROR_BIT  = 5;
  localparam int WAKE_LEVEL_BIT       = 0;

  // ----------------------------------------------------------------------------
  // Values after power-on or soft reset.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] RST_LIN_FAULT_STATUS_B   = 8'h00;
  localparam logic [7:0] RST_WAKE_SOURCE_STATUS_A = 8'h00;
  localparam logic [7:0] RST_WAKE_SOURCE_STATUS_B = 8'h00;
  localparam logic [7:0] RST_READ_DATA            = 8'h00;

  // ----------------------------------------------------------------------------
  // Fault codes of a LIN transceiver.
  // ----------------------------------------------------------------------------
  localparam logic [1:0] FAULT_NONE    = 2'h0;
  localparam logic [1:0] FAULT_THERMAL = 2'h1;
  localparam logic [1:0] FAULT_TXD_DOM = 2'h2;
  localparam logic [1:0] FAULT_BUS_DOM = 2'h3;

  // ----------------------------------------------------------------------------
  // Timing; figures in microseconds are plain defaults, cycles derive from them.
  // ----------------------------------------------------------------------------
  localparam int CLK_MHZ             = 100;
  localparam int TXD_DOM_TIMEOUT_US  = 20000;
  localparam int BUS_DOM_TIMEOUT_US  = 20000;
  localparam int TX_ENABLE_TIME_US   = 10;
  localparam int CNT_W               = 24;
  localparam int TXD_DOM_TIMEOUT_CYC = TXD_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int BUS_DOM_TIMEOUT_CYC = BUS_DOM_TIMEOUT_US * CLK_MHZ;
  localparam int TX_ENABLE_TIME_CYC  = TX_ENABLE_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------------------
  // States of one LIN fault tracker.
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    LIN_NORMAL    = 3'b000,
    LIN_TXD_FAULT = 3'b001,
    LIN_BUS_FAULT = 3'b010,
    LIN_TSD_FAULT = 3'b011,
    LIN_UV_FAULT  = 3'b100,
    LIN_TX_WAIT   = 3'b101
  } bfw_lin_state_t;

endpackage

/* logic/bfw_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Three-stage input synchroniser; a change counts once stages two and three
// agree, which also rejects a single-cycle glitch after metastability.
// ----------------------------------------------------------------------------
module bfw_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Asynchronous levels and their filtered copy.
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } bfw_sync_state_t;

  bfw_sync_state_t r_r;
  bfw_sync_state_t r_nxt;

  // Stage one feeds stage two only; the compare uses stages two and three.
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = async_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < W; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.lvl[i] = r_r.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign level_out = r_r.lvl;

endmodule

/* logic/bfw_lin_fault.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Fault detection and recovery for one LIN transceiver.
// ----------------------------------------------------------------------------
module bfw_lin_fault #(
  parameter logic [bfw_pkg::CNT_W-1:0] TXD_TO_CYC = bfw_pkg::CNT_W'(bfw_pkg::TXD_DOM_TIMEOUT_CYC),
  parameter logic [bfw_pkg::CNT_W-1:0] BUS_TO_CYC = bfw_pkg::CNT_W'(bfw_pkg::BUS_DOM_TIMEOUT_CYC),
  parameter logic [bfw_pkg::CNT_W-1:0] TXEN_CYC   = bfw_pkg::CNT_W'(bfw_pkg::TX_ENABLE_TIME_CYC)
) (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Transceiver conditions, already synchronised.
  input  wire logic       lin_active_in,
  input  wire logic       txd_level_in,
  input  wire logic       bus_level_in,
  input  wire logic       overtemp_in,
  input  wire logic       undervolt_in,
  // Fault report.
  output logic            fault_pulse_out,
  output logic      [1:0] fault_code_out,
  output logic            tsd_pulse_out,
  output logic            tx_enable_out
);

  typedef struct packed {
    bfw_pkg::bfw_lin_state_t   state;
    logic [bfw_pkg::CNT_W-1:0] txd_cnt;
    logic [bfw_pkg::CNT_W-1:0] bus_cnt;
    logic                      pulse;
    logic [1:0]                code;
    logic                      tsd;
  } bfw_lin_fault_state_t;

  bfw_lin_fault_state_t r_r;
  bfw_lin_fault_state_t r_nxt;

  // Counters, state walk and one-cycle fault reports.
  always_comb begin
    r_nxt       = r_r;
    r_nxt.pulse = 1'b0;
    r_nxt.tsd   = 1'b0;
    case (r_r.state)
      bfw_pkg::LIN_NORMAL: begin
        r_nxt.txd_cnt = '0;
        r_nxt.bus_cnt = '0;
        if (!lin_active_in) begin
          r_nxt.state = bfw_pkg::LIN_NORMAL;
        end else if (overtemp_in) begin
          r_nxt.state = bfw_pkg::LIN_TSD_FAULT;
          r_nxt.pulse = 1'b1;
          r_nxt.code  = bfw_pkg::FAULT_THERMAL;
          r_nxt.tsd   = 1'b1;
        end else if (undervolt_in) begin
          r_nxt.state = bfw_pkg::LIN_UV_FAULT;
        end else if (!txd_level_in) begin
          r_nxt.txd_cnt = r_r.txd_cnt + 1'b1;
          if (r_r.txd_cnt >= TXD_TO_CYC - 1'b1) begin
            r_nxt.state = bfw_pkg::LIN_TXD_FAULT;
            r_nxt.pulse = 1'b1;
            r_nxt.code  = bfw_pkg::FAULT_TXD_DOM;
          end
        end else if (!bus_level_in) begin
          r_nxt.bus_cnt = r_r.bus_cnt + 1'b1;
          if (r_r.bus_cnt >= BUS_TO_CYC - 1'b1) begin
            r_nxt.state = bfw_pkg::LIN_BUS_FAULT;
            r_nxt.pulse = 1'b1;
            r_nxt.code  = bfw_pkg::FAULT_BUS_DOM;
          end
        end
      end
      bfw_pkg::LIN_TXD_FAULT: begin
        if (txd_level_in || !lin_active_in) begin
          r_nxt.state   = bfw_pkg::LIN_TX_WAIT;
          r_nxt.txd_cnt = '0;
        end
      end
      bfw_pkg::LIN_BUS_FAULT: begin
        if (bus_level_in || !lin_active_in) begin
          r_nxt.state   = bfw_pkg::LIN_TX_WAIT;
          r_nxt.txd_cnt = '0;
        end
      end
      bfw_pkg::LIN_TSD_FAULT: begin
        if (!overtemp_in) begin
          r_nxt.state   = bfw_pkg::LIN_TX_WAIT;
          r_nxt.txd_cnt = '0;
        end
      end
      bfw_pkg::LIN_UV_FAULT: begin
        if (!undervolt_in) begin
          r_nxt.state   = bfw_pkg::LIN_TX_WAIT;
          r_nxt.txd_cnt = '0;
        end
      end
      bfw_pkg::LIN_TX_WAIT: begin
        if (!txd_level_in) begin
          r_nxt.txd_cnt = '0;
        end else if (r_r.txd_cnt >= TXEN_CYC - 1'b1) begin
          r_nxt.state   = bfw_pkg::LIN_NORMAL;
          r_nxt.txd_cnt = '0;
        end else begin
          r_nxt.txd_cnt = r_r.txd_cnt + 1'b1;
        end
      end
      default: begin
        r_nxt.state = bfw_pkg::LIN_NORMAL;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_r <= '{state: bfw_pkg::LIN_NORMAL, code: bfw_pkg::FAULT_NONE, default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign fault_pulse_out = r_r.pulse;
  assign fault_code_out  = r_r.code;
  assign tsd_pulse_out   = r_r.tsd;
  assign tx_enable_out   = (r_r.state == bfw_pkg::LIN_NORMAL);

endmodule

/* logic/bfw_status_regs.sv */
`timescale 1ns/1ps
module bfw_status_regs #(
  parameter logic [bfw_pkg::CNT_W-1:0] TXD_TO_CYC = bfw_pkg::CNT_W'(bfw_pkg::TXD_DOM_TIMEOUT_CYC),
  parameter logic [bfw_pkg::CNT_W-1:0] BUS_TO_CYC = bfw_pkg::CNT_W'(bfw_pkg::BUS_DOM_TIMEOUT_CYC),
  parameter logic [bfw_pkg::CNT_W-1:0] TXEN_CYC   = bfw_pkg::CNT_W'(bfw_pkg::TX_ENABLE_TIME_CYC)
) (
  // Clock and resets.
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       soft_reset_in,
  // Serial register interface, decoded frame side.
  input  wire logic [6:0] reg_addr_in,
  input  wire logic       reg_rd_in,
  input  wire logic       reg_clr_in,
  output logic      [7:0] reg_rd_data_out,
  output logic            reg_rd_valid_out,
  output logic            reg_addr_hit_out,
  // Pins from outside the clock domain.
  input  wire logic       test_pin_in,
  input  wire logic       wake_input_pin_in,
  input  wire logic       second_lin_transmit_input_in,
  input  wire logic       third_lin_transmit_input_in,
  input  wire logic       second_lin_bus_level_in,
  input  wire logic       third_lin_bus_level_in,
  // Analogue monitors of the two transceivers.
  input  wire logic       second_lin_overtemp_in,
  input  wire logic       third_lin_overtemp_in,
  input  wire logic       lin_supply_undervolt_in,
  // Transceiver modes from the mode control.
  input  wire logic       second_lin_active_in,
  input  wire logic       third_lin_active_in,
  // Event pulses and the fail output config level from logic on this clock.
  input  wire logic       can_wake_in,
  input  wire logic       timer_wake_in,
  input  wire logic       pin_wake_in,
  input  wire logic       first_lin_wake_in,
  input  wire logic       second_lin_wake_in,
  input  wire logic       third_lin_wake_in,
  input  wire logic       regulator_mode_switch_in,
  input  wire logic       fail_output_config_bit_in,
  // Outputs towards the transceivers and thermal status.
  output logic            second_lin_tx_enable_out,
  output logic            third_lin_tx_enable_out,
  output logic            thermal_shutdown_level1_flag_out
);

  // --------------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------------

  typedef struct packed {
    logic [1:0] third_lin_fault_code;
    logic [1:0] second_lin_fault_code;
    logic       regulator_mode_switch_flag;
    logic       can_wake_flag;
    logic       timer_wake_flag;
    logic       pin_wake_flag;
    logic       third_lin_wake_flag;
    logic       second_lin_wake_flag;
    logic       first_lin_wake_flag;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       addr_hit;
    logic       tsd_flag;
  } bfw_regs_state_t;

  bfw_regs_state_t r_r;
  bfw_regs_state_t r_nxt;

  // --------------------------------------------------------------------------
  // Pin synchronisation.
  // --------------------------------------------------------------------------

  logic [8:0] pins_async;
  logic [8:0] pins_sync;

  // One synchroniser bank keeps every pin on the same four-flop latency: three stages and the level register.
  assign pins_async = {test_pin_in, wake_input_pin_in, second_lin_transmit_input_in,
                       third_lin_transmit_input_in, second_lin_bus_level_in,
                       third_lin_bus_level_in, second_lin_overtemp_in,
                       third_lin_overtemp_in, lin_supply_undervolt_in};

  bfw_sync #(
    .W (9)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .async_in  (pins_async),
    .level_out (pins_sync)
  );

  logic test_lvl;
  logic wake_lvl;
  logic txd2_lvl;
  logic txd3_lvl;
  logic bus2_lvl;
  logic bus3_lvl;
  logic ot2_lvl;
  logic ot3_lvl;
  logic uv_lvl;

  assign test_lvl = pins_sync[8];
  assign wake_lvl = pins_sync[7];
  assign txd2_lvl = pins_sync[6];
  assign txd3_lvl = pins_sync[5];
  assign bus2_lvl = pins_sync[4];
  assign bus3_lvl = pins_sync[3];
  assign ot2_lvl  = pins_sync[2];
  assign ot3_lvl  = pins_sync[1];
  assign uv_lvl   = pins_sync[0];

  // --------------------------------------------------------------------------
  // LIN fault trackers.
  // --------------------------------------------------------------------------

  logic       f2_pulse;
  logic [1:0] f2_code;
  logic       f2_tsd;
  logic       f3_pulse;
  logic [1:0] f3_code;
  logic       f3_tsd;

  // Both transceivers share the supply monitor, so undervoltage hits each one whose lin_active_in is high.
  bfw_lin_fault #(
    .TXD_TO_CYC (TXD_TO_CYC),
    .BUS_TO_CYC (BUS_TO_CYC),
    .TXEN_CYC   (TXEN_CYC)
  ) u_lin2 (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .lin_active_in   (second_lin_active_in),
    .txd_level_in    (txd2_lvl),
    .bus_level_in    (bus2_lvl),
    .overtemp_in     (ot2_lvl),
    .undervolt_in    (uv_lvl),
    .fault_pulse_out (f2_pulse),
    .fault_code_out  (f2_code),
    .tsd_pulse_out   (f2_tsd),
    .tx_enable_out   (second_lin_tx_enable_out)
  );

  bfw_lin_fault #(
    .TXD_TO_CYC (TXD_TO_CYC),
    .BUS_TO_CYC (BUS_TO_CYC),
    .TXEN_CYC   (TXEN_CYC)
  ) u_lin3 (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .lin_active_in   (third_lin_active_in),
    .txd_level_in    (txd3_lvl),
    .bus_level_in    (bus3_lvl),
    .overtemp_in     (ot3_lvl),
    .undervolt_in    (uv_lvl),
    .fault_pulse_out (f3_pulse),
    .fault_code_out  (f3_code),
    .tsd_pulse_out   (f3_tsd),
    .tx_enable_out   (third_lin_tx_enable_out)
  );

  // --------------------------------------------------------------------------
  // Register images as the host sees them.
  // --------------------------------------------------------------------------

  logic [7:0] img_lin_fault;
  logic [7:0] img_wake_a;
  logic [7:0] img_wake_b;
  logic [7:0] img_level;

  // Reserved positions stay at their constant values by construction.
  always_comb begin
    img_lin_fault = 8'h00;
    img_wake_a    = 8'h00;
    img_wake_b    = 8'h00;
    img_level     = 8'h00;
    img_lin_fault[bfw_pkg::THIRD_LIN_FAULT_LSB +: 2]  = r_r.third_lin_fault_code;
    img_lin_fault[bfw_pkg::SECOND_LIN_FAULT_LSB +: 2] = r_r.second_lin_fault_code;
    img_wake_a[bfw_pkg::REG_MODE_SWITCH_BIT]          = r_r.regulator_mode_switch_flag;
    img_wake_a[bfw_pkg::CAN_WAKE_BIT]                 = r_r.can_wake_flag;
    img_wake_a[bfw_pkg::TIMER_WAKE_BIT]               = r_r.timer_wake_flag;
    img_wake_a[bfw_pkg::PIN_WAKE_BIT]                 = r_r.pin_wake_flag;
    img_wake_b[bfw_pkg::THIRD_LIN_WAKE_BIT]           = r_r.third_lin_wake_flag;
    img_wake_b[bfw_pkg::SECOND_LIN_WAKE_BIT]          = r_r.second_lin_wake_flag;
    img_wake_b[bfw_pkg::FIRST_LIN_WAKE_BIT]           = r_r.first_lin_wake_flag;
    img_level[bfw_pkg::TEST_LEVEL_BIT]      = test_lvl;
    img_level[bfw_pkg::LEVEL_RSVD_ONE_BIT]  = 1'b1;
    img_level[bfw_pkg::FAIL_CFG_MIRROR_BIT] = fail_output_config_bit_in;
    img_level[bfw_pkg::WAKE_LEVEL_BIT]      = wake_lvl;
  end

  // --------------------------------------------------------------------------
  // Address decode.
  // --------------------------------------------------------------------------

  function automatic logic [1:0] bfw_decode(input logic [6:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    case (addr)
      bfw_pkg::ADDR_LIN_FAULT_STATUS_B:   sel = 2'h0;
      bfw_pkg::ADDR_WAKE_SOURCE_STATUS_A: sel = 2'h1;
      bfw_pkg::ADDR_WAKE_SOURCE_STATUS_B: sel = 2'h2;
      bfw_pkg::ADDR_PIN_LEVEL_STATUS:     sel = 2'h3;
      default:                            sel = 2'h0;
    endcase
    return sel;
  endfunction

  logic       addr_hit;
  logic [1:0] addr_sel;
  logic       clr_fault;
  logic       clr_wake_a;
  logic       clr_wake_b;

  assign addr_hit   = (reg_addr_in >= bfw_pkg::ADDR_LIN_FAULT_STATUS_B)
                    && (reg_addr_in <= bfw_pkg::ADDR_PIN_LEVEL_STATUS);
  assign addr_sel   = bfw_decode(reg_addr_in);
  assign clr_fault  = reg_clr_in && addr_hit && (addr_sel == 2'h0);
  assign clr_wake_a = reg_clr_in && addr_hit && (addr_sel == 2'h1);
  assign clr_wake_b = reg_clr_in && addr_hit && (addr_sel == 2'h2);

  // --------------------------------------------------------------------------
  // Next state: latch events, host clears, read capture.
  // --------------------------------------------------------------------------

  // A new event in the cycle of a clear wins; only a soft reset in the same cycle drops it.
  always_comb begin
    r_nxt          = r_r;
    r_nxt.rd_valid = 1'b0;
    r_nxt.tsd_flag = 1'b0;
    if (clr_fault) begin
      r_nxt.third_lin_fault_code  = bfw_pkg::FAULT_NONE;
      r_nxt.second_lin_fault_code = bfw_pkg::FAULT_NONE;
    end
    if (clr_wake_a) begin
      r_nxt.regulator_mode_switch_flag = 1'b0;
      r_nxt.can_wake_flag              = 1'b0;
      r_nxt.timer_wake_flag            = 1'b0;
      r_nxt.pin_wake_flag              = 1'b0;
    end
    if (clr_wake_b) begin
      r_nxt.third_lin_wake_flag  = 1'b0;
      r_nxt.second_lin_wake_flag = 1'b0;
      r_nxt.first_lin_wake_flag  = 1'b0;
    end
    if (f3_pulse) begin
      r_nxt.third_lin_fault_code = f3_code;
    end
    if (f2_pulse) begin
      r_nxt.second_lin_fault_code = f2_code;
    end
    r_nxt.tsd_flag = f2_tsd || f3_tsd;
    if (regulator_mode_switch_in) begin
      r_nxt.regulator_mode_switch_flag = 1'b1;
    end
    if (can_wake_in) begin
      r_nxt.can_wake_flag = 1'b1;
    end
    if (timer_wake_in) begin
      r_nxt.timer_wake_flag = 1'b1;
    end
    if (pin_wake_in) begin
      r_nxt.pin_wake_flag = 1'b1;
    end
    if (third_lin_wake_in) begin
      r_nxt.third_lin_wake_flag = 1'b1;
    end
    if (second_lin_wake_in) begin
      r_nxt.second_lin_wake_flag = 1'b1;
    end
    if (first_lin_wake_in) begin
      r_nxt.first_lin_wake_flag = 1'b1;
    end
    if (reg_rd_in) begin
      r_nxt.rd_valid = 1'b1;
      r_nxt.addr_hit = addr_hit;
      r_nxt.rd_data  = 8'h00;
      if (addr_hit) begin
        case (addr_sel)
          2'h0:    r_nxt.rd_data = img_lin_fault;
          2'h1:    r_nxt.rd_data = img_wake_a;
          2'h2:    r_nxt.rd_data = img_wake_b;
          default: r_nxt.rd_data = img_level;
        endcase
      end
    end
    if (soft_reset_in) begin
      r_nxt = '{default: '0};
    end
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_r <= '{default: '0};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign reg_rd_data_out                  = r_r.rd_data;
  assign reg_rd_valid_out                 = r_r.rd_valid;
  assign reg_addr_hit_out                 = r_r.addr_hit;
  assign thermal_shutdown_level1_flag_out = r_r.tsd_flag;

endmodule

/* verification/bfw_props.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checks for the status register group.
// ----------------------------------------------------------------------------
module bfw_props (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       soft_reset_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic       fail_output_config_bit_in,
  input wire logic [7:0] reg_rd_data_out,
  input wire logic       reg_rd_valid_out,
  input wire logic       reg_addr_hit_out,
  input wire logic       thermal_shutdown_level1_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_read_answer: assert property (reg_rd_in && !soft_reset_in |=> reg_rd_valid_out)
    else $error("read not answered");
  a_valid_cause: assert property (reg_rd_valid_out |-> $past(reg_rd_in))
    else $error("valid without read");
  a_fault_rsvd: assert property (reg_rd_valid_out && $past(reg_addr_in) == 7'h45
    |-> (reg_rd_data_out & 8'hE1) == 8'h00) else $error("fault reserved bits");
  a_wake_a_rsvd: assert property (reg_rd_valid_out && $past(reg_addr_in) == 7'h46
    |-> (reg_rd_data_out & 8'h4E) == 8'h00) else $error("wake a reserved bits");
  a_wake_b_rsvd: assert property (reg_rd_valid_out && $past(reg_addr_in) == 7'h47
    |-> (reg_rd_data_out & 8'hF8) == 8'h00) else $error("wake b reserved bits");
  a_level_fixed: assert property (reg_rd_valid_out && $past(reg_addr_in) == 7'h48
    |-> (reg_rd_data_out & 8'h5E) == 8'h40) else $error("level fixed bits");
  a_level_cfg: assert property (reg_rd_valid_out && $past(reg_addr_in) == 7'h48
    |-> reg_rd_data_out[5] == $past(fail_output_config_bit_in)) else $error("cfg mirror");
  a_hit_decode: assert property (reg_rd_valid_out |-> reg_addr_hit_out ==
    ($past(reg_addr_in) >= 7'h45 && $past(reg_addr_in) <= 7'h48)) else $error("hit decode");
  a_soft_clear: assert property (soft_reset_in |=> !reg_rd_valid_out &&
    reg_rd_data_out == 8'h00 && !reg_addr_hit_out) else $error("soft reset clear");
  a_tsd_pulse: assert property ($rose(thermal_shutdown_level1_flag_out)
    |=> !thermal_shutdown_level1_flag_out) else $error("thermal flag not one cycle");
  c_read: cover property (reg_rd_valid_out && reg_addr_hit_out);
  c_tsd: cover property (thermal_shutdown_level1_flag_out);
  c_soft: cover property (soft_reset_in);
endmodule

/* verification/bfw_host.sv */
`timescale 1ns/1ps
module bfw_host (
  input  wire logic       clk_in,
  output logic      [6:0] reg_addr_out,
  output logic            reg_rd_out,
  output logic            reg_clr_out
);
  initial {reg_addr_out, reg_rd_out, reg_clr_out} = 9'h000;
  // host reads and clears
  // One strobe per access; the released address is inverted so nothing stale matches.
  task automatic op(input logic [6:0] a, input logic rd, input logic clr);
    @(posedge clk_in);
    {reg_addr_out, reg_rd_out, reg_clr_out} <= {a, rd, clr};
    @(posedge clk_in);
    {reg_addr_out, reg_rd_out, reg_clr_out} <= {~a, 2'b00};
  endtask
endmodule

/* verification/bfw_status_regs_bench.sv */
`timescale 1ns/1ps
module bfw_status_regs_bench;
  logic clk_in = 1'b0;
  logic rst_in, soft_reset_in, reg_rd_in, reg_clr_in, test_pin_in, wake_input_pin_in;
  logic second_lin_transmit_input_in, third_lin_transmit_input_in, second_lin_bus_level_in;
  logic third_lin_bus_level_in, second_lin_overtemp_in, third_lin_overtemp_in;
  logic lin_supply_undervolt_in, second_lin_active_in, third_lin_active_in;
  logic can_wake_in, timer_wake_in, pin_wake_in, first_lin_wake_in, second_lin_wake_in;
  logic third_lin_wake_in, regulator_mode_switch_in, fail_output_config_bit_in;
  logic reg_rd_valid_out, reg_addr_hit_out, second_lin_tx_enable_out, third_lin_tx_enable_out;
  logic thermal_shutdown_level1_flag_out;
  logic [6:0] reg_addr_in, ev, ea;
  logic [7:0] reg_rd_data_out;
  logic [8:0] exp_q[$], e9;
  logic tsd_seen = 1'b0;
  logic [31:0] rnd = 32'h55BB;
  int mismatches = 0;
  int checks = 0;
  // Event pulses in table order: can, timer, pin, lin1, lin2, lin3, mode switch.
  localparam logic [55:0] EV_V = 56'h80_04_02_01_01_10_20;
  assign {regulator_mode_switch_in, third_lin_wake_in, second_lin_wake_in, first_lin_wake_in,
          pin_wake_in, timer_wake_in, can_wake_in} = ev;
  always #5 clk_in = ~clk_in;
  bfw_status_regs #(.TXD_TO_CYC(24'h8), .BUS_TO_CYC(24'h8), .TXEN_CYC(24'h4)) dut (.*);
  bfw_host host (.clk_in(clk_in), .reg_addr_out(reg_addr_in), .reg_rd_out(reg_rd_in),
                 .reg_clr_out(reg_clr_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    if (exp_q.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back({(a >= 7'h45 && a <= 7'h48), e});
    host.op(a, 1'b1, 1'b0);
  endtask
  // Bounded wait for the transmit enables; the latency depends on synchroniser stages.
  task automatic wait_tx(input logic [1:0] w);
    int n;
    n = 0;
    while ({third_lin_tx_enable_out, second_lin_tx_enable_out} !== w && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    check("tx_enable", {6'h00, third_lin_tx_enable_out, second_lin_tx_enable_out}, {6'h00, w});
    if (n == 200) close_out();
    repeat (3) @(posedge clk_in);
  endtask
  // Read data is taken off the queue on the falling edge, where it has settled.
  always @(negedge clk_in) begin
    if (thermal_shutdown_level1_flag_out === 1'b1) tsd_seen = 1'b1;
    if (reg_rd_valid_out === 1'b1) begin
      if (exp_q.size() == 0) mismatches++;
      else begin
        e9 = exp_q.pop_front();
        check("reg_rd_data", reg_rd_data_out, e9[7:0]);
        check("reg_addr_hit", {7'h00, reg_addr_hit_out}, {7'h00, e9[8]});
      end
    end
  end
  initial begin
    #400us;
    mismatches++;
    close_out();
  end
  // Main sequence: reset, wake flags, levels, fault codes, soft reset.
  initial begin
    {rst_in, soft_reset_in, test_pin_in, wake_input_pin_in, fail_output_config_bit_in} = 5'h10;
    {second_lin_overtemp_in, third_lin_overtemp_in, lin_supply_undervolt_in, ev} = 10'h000;
    {second_lin_transmit_input_in, third_lin_transmit_input_in, second_lin_bus_level_in,
     third_lin_bus_level_in, second_lin_active_in, third_lin_active_in} = 6'h3F;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 3; a++) rd(7'h45 + a[6:0], 8'h00);
    for (int i = 0; i < 7; i++) begin
      ea = (i > 2 && i < 6) ? 7'h47 : 7'h46;
      @(posedge clk_in) ev <= 7'h01 << i;
      @(posedge clk_in) ev <= 7'h00;
      rd(ea, EV_V[8*i+:8]);
      host.op(ea, 1'b0, 1'b1);
      rd(ea, 8'h00);
    end
    $display("wake flags done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      @(posedge clk_in) {test_pin_in, wake_input_pin_in, fail_output_config_bit_in} <= rnd[2:0];
      repeat (6) @(posedge clk_in);
      host.op(7'h48, 1'b0, 1'b1);
      rd(7'h48, {rnd[2], 1'b1, rnd[0], 4'h0, rnd[1]});
    end
    rd(7'h49, 8'h00);
    rd(7'h44, 8'h00);
    $display("levels done");
    @(posedge clk_in) second_lin_overtemp_in <= 1'b1;
    wait_tx(2'b10);
    rd(7'h45, 8'h02);
    check("tsd_flag", {7'h00, tsd_seen}, 8'h01);
    @(posedge clk_in) second_lin_overtemp_in <= 1'b0;
    wait_tx(2'b11);
    @(posedge clk_in) third_lin_transmit_input_in <= 1'b0;
    wait_tx(2'b01);
    rd(7'h45, 8'h12);
    @(posedge clk_in) third_lin_transmit_input_in <= 1'b1;
    wait_tx(2'b11);
    host.op(7'h45, 1'b0, 1'b1);
    rd(7'h45, 8'h00);
    @(posedge clk_in) second_lin_bus_level_in <= 1'b0;
    wait_tx(2'b10);
    rd(7'h45, 8'h06);
    @(posedge clk_in) second_lin_active_in <= 1'b0;
    wait_tx(2'b11);
    @(posedge clk_in) {second_lin_bus_level_in, lin_supply_undervolt_in} <= 2'b11;
    @(posedge clk_in) second_lin_active_in <= 1'b1;
    wait_tx(2'b00);
    @(posedge clk_in) lin_supply_undervolt_in <= 1'b0;
    wait_tx(2'b11);
    $display("fault codes done");
    @(posedge clk_in) ev <= 7'h01;
    @(posedge clk_in) {ev, soft_reset_in} <= 8'h01;
    @(posedge clk_in) soft_reset_in <= 1'b0;
    rd(7'h46, 8'h00);
    rd(7'h45, 8'h00);
    repeat (4) @(posedge clk_in);
    $display("soft reset done");
    close_out();
  end
endmodule
bind bfw_status_regs bfw_props chk (.*);
